// ==== src/mid_pkg.sv ====
// Purpose: Shared constants and types for the instruction decoder core
// Assumes: 13-bit instruction words, 8-bit data path, AHB-Lite register access
// Notes:   Bus offsets, status bit positions and control register reset values live here
package mid_pkg;

  // ************
  // Core widths
  // ************
  localparam int unsigned IW = 13;
  localparam int unsigned DW = 8;
  localparam int unsigned PW = 12;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned NREG = 64;
  localparam int unsigned NPCTRL = 16;

  // ************
  // Clock figures
  // ************
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned CLKS_PER_CYCLE = 2;

  // ************
  // Special register indexes and fields
  // ************
  localparam logic [5:0] REG_PCL = 6'h02;
  localparam logic [5:0] REG_STATUS = 6'h03;
  localparam logic [3:0] PCTRL_FIRST = 4'h5;
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_P = 3;
  localparam int unsigned ST_T = 4;
  localparam int unsigned ST_PG_LO = 5;

  // ************
  // Fixed encodings
  // ************
  localparam logic [12:0] ENC_NOP = 13'h0000;
  localparam logic [12:0] ENC_DAA = 13'h0001;
  localparam logic [12:0] ENC_CFGW = 13'h0002;
  localparam logic [12:0] ENC_SLEEP = 13'h0003;
  localparam logic [12:0] ENC_WATCHDOG_CLEAR_INSTR = 13'h0004;
  localparam logic [12:0] ENC_IEN = 13'h0010;
  localparam logic [12:0] ENC_IDIS = 13'h0011;
  localparam logic [12:0] ENC_RET = 13'h0012;
  localparam logic [12:0] ENC_RETURN_FROM_IRQ_INSTR = 13'h0013;
  localparam logic [12:0] ENC_CFGR = 13'h0014;

  // ************
  // Bus register map
  // ************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CORE = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam int unsigned CTRL_CYC = 0;
  localparam int unsigned CTRL_RUN = 1;
  localparam logic CTRL_CYC_RST = 1'b1;
  localparam logic CTRL_RUN_RST = 1'b0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    MID_FETCH  = 2'b00,
    MID_EXEC   = 2'b01,
    MID_STALL0 = 2'b11,
    MID_STALL1 = 2'b10
  } mid_state_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] ofs;
  } mid_wreq_t;

endpackage

// ==== src/mid_core.sv ====
// Purpose: Decode and execute 13-bit instructions of an 8-bit controller core
// Assumes: Program ROM answers the fetch address within the same instruction cycle
// Notes:   Software starts the core and picks the PC-write cycle option over AHB-Lite
`timescale 1ns/1ns
`default_nettype none
module mid_core
  import mid_pkg::*;
(
  // Clock and reset
  input  wire logic          mclk_i,
  input  wire logic          arst_n_i,
  // AHB-Lite slave
  input  wire logic          hsel_i,
  input  wire logic [31:0]   haddr_i,
  input  wire logic [1:0]    htrans_i,
  input  wire logic          hwrite_i,
  input  wire logic [2:0]    hsize_i,
  input  wire logic [31:0]   hwdata_i,
  input  wire logic          hready_i,
  output logic               hreadyout_o,
  output logic               hresp_o,
  output logic [31:0]        hrdata_o,
  // Program ROM
  output logic [PW-1:0]      rom_addr_o,
  input  wire logic [IW-1:0] rom_data_i,
  // Wake pin and core side effects
  input  wire logic          wake_i,
  output logic               sleep_o,
  output logic               wdt_clr_o,
  output logic               irq_en_o,
  output logic [DW-1:0]      mode_cfg_o
);

  // ************
  // State
  // ************
  mid_state_t            state_ff, nxt_state;
  logic [PW-1:0]         pc_ff;
  logic [DW-1:0]         acc_ff, mcfg_ff;
  logic [DW-1:0]         regs_ff [NREG];
  logic [DW-1:0]         pctrl_ff [NPCTRL];
  logic [PW-1:0]         stack_ff [STACK_DEPTH];
  logic [2:0]            sp_ff;
  logic                  fz_ff, fc_ff, fdc_ff, ft_ff, fp_ff;
  logic [1:0]            page_ff;
  logic                  skip_ff, ien_ff, sleep_ff, watchdog_clear_instr_ff;
  logic                  cyc_opt_ff, run_ff;
  logic                  wake_s1_ff, wake_s2_ff;
  mid_wreq_t             wreq_ff;
  logic [31:0]           hrdata_ff;

  // ************
  // Field decode
  // ************
  wire logic [IW-1:0] ins = rom_data_i;
  wire logic [5:0]    rr = ins[5:0];
  wire logic [2:0]    bsel = ins[8:6];
  wire logic [9:0]    k10 = ins[9:0];
  wire logic [7:0]    k8 = ins[7:0];
  wire logic          is_lit = ins[12];
  wire logic          is_bit = !ins[12] && ins[11];
  wire logic          is_reg = !ins[12] && !ins[11];
  wire logic [4:0]    rop = ins[10:6];
  wire logic          is_misc = is_reg && (rop == 5'h00);
  wire logic          exec_ok = (state_ff == MID_EXEC) && !skip_ff;

  // Status register view and register read mux; port control registers are read separately
  wire logic [DW-1:0] status_v = {1'b0, page_ff, ft_ff, fp_ff, fz_ff, fdc_ff, fc_ff};
  wire logic [DW-1:0] rval = (rr == REG_PCL) ? pc_ff[7:0] :
                             (rr == REG_STATUS) ? status_v : regs_ff[rr];
  wire logic          rbit = rval[bsel];

  // Fixed encodings take precedence over port control access
  wire logic is_fixed = (ins <= ENC_WATCHDOG_CLEAR_INSTR) || ((ins >= ENC_IEN) && (ins <= ENC_CFGR));
  wire logic is_pcw = is_misc && !ins[4] && !is_fixed && (ins[3:0] >= PCTRL_FIRST);
  wire logic is_pcr = is_misc && ins[4] && !is_fixed && (ins[3:0] >= PCTRL_FIRST);

  // ************
  // Datapath
  // ************
  logic [DW-1:0] res;
  logic          wr_a, wr_r, upd_z, upd_c, upd_dc, n_c, n_dc, do_skip;
  logic [8:0]    sum9;
  logic [4:0]    sum5;
  logic [DW-1:0] opnd;

  always_comb
  begin
    res = '0;
    wr_a = 1'b0;
    wr_r = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    n_c = fc_ff;
    n_dc = fdc_ff;
    do_skip = 1'b0;
    opnd = is_lit ? k8 : rval;
    // Shared adder: sub is operand minus acc, carry set when no borrow
    if ((is_reg && (rop == 5'h04 || rop == 5'h05)) || (is_lit && ins[10:8] == 3'h5))
    begin
      sum9 = {1'b0, opnd} + {1'b0, ~acc_ff} + 9'h001;
      sum5 = {1'b0, opnd[3:0]} + {1'b0, ~acc_ff[3:0]} + 5'h01;
    end
    else
    begin
      sum9 = {1'b0, opnd} + {1'b0, acc_ff};
      sum5 = {1'b0, opnd[3:0]} + {1'b0, acc_ff[3:0]};
    end
    if (is_reg)
    begin
      wr_r = rop[0] && (rop >= 5'h04);
      wr_a = !rop[0] && (rop >= 5'h04);
      case (rop)
        5'h00:
        begin
          if (ins == ENC_DAA)
          begin
            // Decimal adjust of the accumulator, carry only
            sum9 = {1'b0, acc_ff} + (((acc_ff[3:0] > 4'h9) || fdc_ff) ? 9'h006 : 9'h000);
            if ((sum9[7:4] > 4'h9) || fc_ff || sum9[8])
              sum9 = sum9 + 9'h060;
            res = sum9[7:0];
            wr_a = 1'b1;
            upd_c = 1'b1;
            n_c = sum9[8] || fc_ff;
          end
          else if (ins == ENC_CFGR)
          begin
            res = mcfg_ff;
            wr_a = 1'b1;
          end
          else if (is_pcr)
          begin
            res = pctrl_ff[ins[3:0]];
            wr_a = 1'b1;
          end
        end
        5'h01: begin res = acc_ff; wr_r = 1'b1; end
        5'h02: begin res = '0; wr_a = 1'b1; upd_z = 1'b1; end
        5'h03: begin res = '0; wr_r = 1'b1; upd_z = 1'b1; end
        5'h04, 5'h05, 5'h0e, 5'h0f:
        begin
          res = sum9[7:0];
          upd_z = 1'b1;
          upd_c = 1'b1;
          upd_dc = 1'b1;
          n_c = sum9[8];
          n_dc = sum5[4];
        end
        5'h06, 5'h07: begin res = rval - 8'h01; upd_z = 1'b1; end
        5'h08, 5'h09: begin res = acc_ff | rval; upd_z = 1'b1; end
        5'h0a, 5'h0b: begin res = acc_ff & rval; upd_z = 1'b1; end
        5'h0c, 5'h0d: begin res = acc_ff ^ rval; upd_z = 1'b1; end
        5'h10, 5'h11: begin res = rval; upd_z = 1'b1; end
        5'h12, 5'h13: begin res = ~rval; upd_z = 1'b1; end
        5'h14, 5'h15: begin res = rval + 8'h01; upd_z = 1'b1; end
        5'h16, 5'h17:
        begin
          res = rval - 8'h01;
          do_skip = (res == '0);
        end
        5'h18, 5'h19: begin res = {fc_ff, rval[7:1]}; upd_c = 1'b1; n_c = rval[0]; end
        5'h1a, 5'h1b: begin res = {rval[6:0], fc_ff}; upd_c = 1'b1; n_c = rval[7]; end
        5'h1c, 5'h1d: res = {rval[3:0], rval[7:4]};
        5'h1e, 5'h1f:
        begin
          res = rval + 8'h01;
          do_skip = (res == '0);
        end
        default: res = '0;
      endcase
    end
    else if (is_bit)
    begin
      // Bit ops: 00 clear, 01 set, 10 skip if clear, 11 skip if set
      res = rval;
      res[bsel] = ins[9];
      wr_r = !ins[10];
      do_skip = ins[10] && (rbit == ins[9]);
    end
    else if (ins[11])
    begin
      wr_a = (ins[10:8] != 3'h6);
      case (ins[10:8])
        3'h0, 3'h4: res = k8;
        3'h1: begin res = acc_ff | k8; upd_z = 1'b1; end
        3'h2: begin res = acc_ff & k8; upd_z = 1'b1; end
        3'h3: begin res = acc_ff ^ k8; upd_z = 1'b1; end
        3'h5, 3'h7:
        begin
          res = sum9[7:0];
          upd_z = 1'b1;
          upd_c = 1'b1;
          upd_dc = 1'b1;
          n_c = sum9[8];
          n_dc = sum5[4];
        end
        default: res = '0;
      endcase
    end
  end

  // Control flow decode
  wire logic pc_wr = exec_ok && wr_r && (rr == REG_PCL);
  wire logic is_ret = is_misc && ((ins == ENC_RET) || (ins == ENC_RETURN_FROM_IRQ_INSTR));
  wire logic is_return_with_literal = is_lit && (ins[11:8] == 4'hc);
  wire logic is_call = is_lit && (ins[11:10] == 2'b00);
  wire logic is_jmp = is_lit && (ins[11:10] == 2'b01);
  wire logic [PW-1:0] pc_inc = pc_ff + 12'h001;
  wire logic [PW-1:0] pc_lit = {page_ff, k10};
  wire logic [2:0]    sp_top = sp_ff - 3'h1;
  wire logic [PW-1:0] pc_next = !exec_ok ? pc_inc :
                               (is_call || is_jmp) ? pc_lit :
                               (is_ret || is_return_with_literal) ? stack_ff[sp_top] :
                               pc_wr ? {pc_ff[11:8], res} : pc_inc;

  // ************
  // Sequencer
  // ************
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      MID_FETCH: if (run_ff && !sleep_ff) nxt_state = MID_EXEC;
      MID_EXEC: nxt_state = (pc_wr && cyc_opt_ff) ? MID_STALL0 : MID_FETCH;
      MID_STALL0: nxt_state = MID_STALL1;
      MID_STALL1: nxt_state = MID_FETCH;
      default: nxt_state = MID_FETCH;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff <= MID_FETCH;
      pc_ff <= '0;
      acc_ff <= '0;
      mcfg_ff <= '0;
      sp_ff <= '0;
      {fz_ff, fc_ff, fdc_ff} <= '0;
      {ft_ff, fp_ff} <= 2'b11;
      page_ff <= '0;
      skip_ff <= 1'b0;
      ien_ff <= 1'b0;
      sleep_ff <= 1'b0;
      watchdog_clear_instr_ff <= 1'b0;
      wake_s1_ff <= 1'b0;
      wake_s2_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      wake_s1_ff <= wake_i;
      wake_s2_ff <= wake_s1_ff;
      watchdog_clear_instr_ff <= exec_ok && ((ins == ENC_SLEEP) || (ins == ENC_WATCHDOG_CLEAR_INSTR));
      if (wake_s2_ff)
        sleep_ff <= 1'b0;
      if (state_ff == MID_EXEC)
      begin
        pc_ff <= pc_next;
        skip_ff <= exec_ok && do_skip;
      end
      if (exec_ok)
      begin
        if (wr_a)
          acc_ff <= res;
        if (upd_z)
          fz_ff <= (res == '0);
        if (upd_c)
          fc_ff <= n_c;
        if (upd_dc)
          fdc_ff <= n_dc;
        if (wr_r && rr == REG_STATUS)
        begin
          {page_ff, ft_ff, fp_ff} <= res[6:3];
          if (!upd_z)
            fz_ff <= res[ST_Z];
          if (!upd_c)
            fc_ff <= res[ST_C];
          if (!upd_dc)
            fdc_ff <= res[ST_DC];
        end
        if (ins == ENC_CFGW)
          mcfg_ff <= acc_ff;
        if (ins == ENC_SLEEP)
        begin
          {ft_ff, fp_ff} <= 2'b10;
          sleep_ff <= 1'b1;
        end
        if (ins == ENC_WATCHDOG_CLEAR_INSTR)
          {ft_ff, fp_ff} <= 2'b11;
        if (ins == ENC_IEN || ins == ENC_RETURN_FROM_IRQ_INSTR)
          ien_ff <= 1'b1;
        if (ins == ENC_IDIS)
          ien_ff <= 1'b0;
        if (is_call)
        begin
          stack_ff[sp_ff] <= pc_inc;
          sp_ff <= sp_ff + 3'h1;
        end
        if (is_ret || is_return_with_literal)
          sp_ff <= sp_top;
      end
    end
  end

  // General and port control registers have no reset, like plain RAM
  always_ff @(posedge mclk_i)
  begin
    if (exec_ok && wr_r && rr != REG_PCL && rr != REG_STATUS)
      regs_ff[rr] <= res;
    if (exec_ok && is_pcw)
      pctrl_ff[ins[3:0]] <= acc_ff;
  end

  // ************
  // AHB-Lite slave, zero wait states
  // ************
  wire logic        acc_phase = hsel_i && htrans_i[1] && hready_i;
  wire logic [7:0]  aofs = haddr_i[7:0];
  wire logic [31:0] rd_mux = (aofs == OFS_CTRL) ? {30'h0, run_ff, cyc_opt_ff} :
                             (aofs == OFS_CORE) ? {11'h0, sp_ff, sleep_ff, ien_ff, status_v, acc_ff} :
                             (aofs == OFS_PC) ? {20'h0, pc_ff} : 32'h0;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wreq_ff <= '0;
      hrdata_ff <= '0;
      cyc_opt_ff <= CTRL_CYC_RST;
      run_ff <= CTRL_RUN_RST;
    end
    else
    begin
      wreq_ff.wr <= acc_phase && hwrite_i && (hsize_i == HSIZE_WORD);
      wreq_ff.ofs <= aofs;
      if (acc_phase && !hwrite_i)
        hrdata_ff <= rd_mux;
      if (wreq_ff.wr && wreq_ff.ofs == OFS_CTRL)
      begin
        cyc_opt_ff <= hwdata_i[CTRL_CYC];
        run_ff <= hwdata_i[CTRL_RUN];
      end
    end
  end

  // ************
  // Outputs
  // ************
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_ff;
  assign rom_addr_o = pc_ff;
  assign sleep_o = sleep_ff;
  assign wdt_clr_o = watchdog_clear_instr_ff;
  assign irq_en_o = ien_ff;
  assign mode_cfg_o = mcfg_ff;

  // ************
  // Assertions
  // ************
  property p_exec_after_fetch;
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_ff == MID_EXEC |-> $past(state_ff) == MID_FETCH;
  endproperty
  a_exec_after_fetch: assert property (p_exec_after_fetch) else $error("exec not preceded by fetch");

  property p_stall_two;
    @(posedge mclk_i) disable iff (!arst_n_i)
    pc_wr && cyc_opt_ff |=> state_ff == MID_STALL0 ##1 state_ff == MID_STALL1 ##1 state_ff == MID_FETCH;
  endproperty
  a_stall_two: assert property (p_stall_two) else $error("pc write did not stall one cycle");

  property p_no_stall;
    @(posedge mclk_i) disable iff (!arst_n_i)
    pc_wr && !cyc_opt_ff |=> state_ff == MID_FETCH && pc_ff[7:0] == $past(res);
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("single cycle pc write wrong");

  property p_skip_set;
    @(posedge mclk_i) disable iff (!arst_n_i)
    exec_ok && do_skip |=> skip_ff ##2 !skip_ff;
  endproperty
  a_skip_set: assert property (p_skip_set) else $error("skip not taken once");

  property p_skip_quiet;
    @(posedge mclk_i) disable iff (!arst_n_i)
    state_ff == MID_EXEC && skip_ff |=> $stable(acc_ff) && $stable(fz_ff) && $stable(fc_ff);
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("skipped instruction had effect");

  property p_bit_value;
    @(posedge mclk_i) disable iff (!arst_n_i)
    exec_ok && is_bit && !ins[10] && rr > REG_STATUS |=> regs_ff[$past(rr)][$past(bsel)] == $past(ins[9]);
  endproperty
  a_bit_value: assert property (p_bit_value) else $error("bit clear or set wrong");

  property p_irq_on;
    @(posedge mclk_i) disable iff (!arst_n_i)
    exec_ok && (ins == ENC_IEN || ins == ENC_RETURN_FROM_IRQ_INSTR) |=> irq_en_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupts not enabled");

  property p_logic_carry;
    @(posedge mclk_i) disable iff (!arst_n_i)
    exec_ok && is_reg && rop >= 5'h08 && rop <= 5'h0d |=> $stable(fc_ff) && $stable(fdc_ff);
  endproperty
  a_logic_carry: assert property (p_logic_carry) else $error("logic op changed carry");

  property p_call_push;
    @(posedge mclk_i) disable iff (!arst_n_i)
    exec_ok && is_call |=> sp_ff == $past(sp_ff) + 3'h1 && pc_ff == $past(pc_lit);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call did not push and jump");

  c_skip: cover property (@(posedge mclk_i) disable iff (!arst_n_i) exec_ok && do_skip);
  c_stall: cover property (@(posedge mclk_i) disable iff (!arst_n_i) state_ff == MID_STALL1);
  c_ret: cover property (@(posedge mclk_i) disable iff (!arst_n_i) exec_ok && is_ret);

endmodule
`default_nettype wire

// ==== tb/mid_rom_model.sv ====
// Purpose: Program ROM model that feeds instruction words to the core
// Assumes: Bench loads mem while the core is held in reset
// Notes:   DLY_NS models a slow ROM answer that still lands inside the instruction cycle
`timescale 1ns/1ns
`default_nettype none
module mid_rom_model
  import mid_pkg::*;
#(
  parameter int DLY_NS = 20
)
(
  // Fetch side
  input  wire logic [PW-1:0] rom_addr_i,
  output logic [IW-1:0]      rom_data_o
);
  // ************
  // Storage
  // ************
  logic [IW-1:0] mem [0:(1<<PW)-1];

  // Whole 13-bit word per fetch address, late by DLY_NS
  assign #(DLY_NS) rom_data_o = mem[rom_addr_i];
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the instruction decoder core
// Assumes: Programs run from the ROM model, results read over AHB-Lite
// Notes:   Programs park in a jump-to-self loop or in sleep before results are read
`timescale 1ns/1ns
`default_nettype none
module testbench
  import mid_pkg::*;
;
  logic          mclk_i = 1'b0;
  logic          arst_n_i = 1'b0;
  logic          hsel = 1'b0;
  logic          hwrite = 1'b0;
  logic [31:0]   haddr = 32'h0;
  logic [31:0]   hwdata = 32'h0;
  logic [1:0]    htrans = 2'h0;
  logic [2:0]    hsize = 3'h0;
  logic          wake = 1'b0;
  logic          hready;
  logic          hresp;
  logic [31:0]   hrdata;
  logic [PW-1:0] rom_addr;
  logic [IW-1:0] rom_data;
  logic          sleep;
  logic          wdt_clr;
  logic          irq_en;
  logic [DW-1:0] mode_cfg;
  logic [31:0]   rd;
  logic [12:0]   q[$];
  int            miscompares = 0;
  int            check_count = 0;
  int            wdt_pulses = 0;
  int            d0;
  int            d1;

  mid_core DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
    .hresp_o(hresp), .hrdata_o(hrdata), .rom_addr_o(rom_addr), .rom_data_i(rom_data), .wake_i(wake),
    .sleep_o(sleep), .wdt_clr_o(wdt_clr), .irq_en_o(irq_en), .mode_cfg_o(mode_cfg));

  mid_rom_model ROM (.rom_addr_i(rom_addr), .rom_data_o(rom_data));

  always #(CLK_NS/2) mclk_i = ~mclk_i;

  always @(posedge mclk_i)
    if (wdt_clr === 1'b1)
      wdt_pulses++;

  // ************
  // Bus and check tasks
  // ************
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz,
                     output logic [31:0] r);
    @(posedge mclk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    do @(posedge mclk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_i); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, HSIZE_WORD, r);
    chk(nm, e, r);
  endtask

  task automatic restart;
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    foreach (q[i]) ROM.mem[i] = q[i];
    wdt_pulses = 0;
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
  endtask

  task automatic run(input logic cyc, input int n);
    restart();
    ahb(1'b1, OFS_CTRL, {30'h0, 1'b1, cyc}, HSIZE_WORD, rd);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic meas(input logic cyc, output int n);
    restart();
    ahb(1'b1, OFS_CTRL, {30'h0, 1'b1, cyc}, HSIZE_WORD, rd);
    n = 0;
    while (wdt_clr !== 1'b1 && n < 200)
    begin
      @(negedge mclk_i);
      n++;
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ************
  // Scenarios
  // ************
  initial
  begin
    q = '{13'h0000};
    restart();
    rchk("ctrl reset", OFS_CTRL, {30'h0, CTRL_RUN_RST, CTRL_CYC_RST});
    rchk("core reset", OFS_CORE, 32'h0000_1800);
    rchk("pc reset", OFS_PC, 32'h0);
    rchk("unmapped", 8'h0c, 32'h0);
    ahb(1'b1, OFS_CTRL, 32'h0, 3'h0, rd);
    rchk("ctrl byte write", OFS_CTRL, 32'h1);
    chk("hresp", 32'h0, {31'h0, hresp});
    // Literal add with carries, interrupt enable, undefined literal group
    q = '{13'h180f, 13'h1ff1, 13'h0010, 13'h1e12, 13'h1404};
    run(1'b1, 40);
    rchk("core add", OFS_CORE, 32'h0001_1f00);
    rchk("pc jump", OFS_PC, 32'h4);
    chk("irq_en", 32'h1, {31'h0, irq_en});
    // Call, decrement-and-skip, return with literal
    q = '{13'h1801, 13'h0051, 13'h1008, 13'h05d1, 13'h18ee, 13'h1405, 13'h0000, 13'h0000, 13'h1c42};
    run(1'b1, 60);
    rchk("core call", OFS_CORE, 32'h0000_1842);
    rchk("pc call", OFS_PC, 32'h5);
    // Mode config, port control, bit ops on register 16 only, logic ops, watchdog clear
    q = '{13'h1833, 13'h0002, 13'h0050, 13'h0006, 13'h1800, 13'h0016, 13'h0ad0, 13'h0ed0,
          13'h1855, 13'h0cd0, 13'h1af0, 13'h0210, 13'h0350, 13'h0004, 13'h140e};
    run(1'b1, 80);
    ahb(1'b0, OFS_CORE, 32'h0, HSIZE_WORD, rd);
    chk("acc and flags", 32'h43b, rd & 32'h7ff);
    chk("mode cfg", 32'h33, {24'h0, mode_cfg});
    chk("wdt pulses", 32'h1, wdt_pulses);
    rchk("pc bits", OFS_PC, 32'he);
    // Decimal adjust, subtract, rotate, swap, config read, call with interrupt return, sleep and wake
    q = '{13'h189a, 13'h0001, 13'h1d05, 13'h0051, 13'h0611, 13'h0751, 13'h0014, 13'h0411, 13'h0551,
          13'h0491, 13'h0010, 13'h0011, 13'h1010, 13'h0003, 13'h140e, 13'h0000, 13'h0013};
    run(1'b1, 60);
    rchk("core sleep", OFS_CORE, 32'h0003_13ae);
    chk("sleep", 32'h1, {31'h0, sleep});
    chk("wdt sleep", 32'h1, wdt_pulses);
    rchk("pc sleep", OFS_PC, 32'he);
    wake <= 1'b1;
    repeat (10) @(posedge mclk_i);
    wake <= 1'b0;
    rchk("core wake", OFS_CORE, 32'h0001_13ae);
    chk("sleep woken", 32'h0, {31'h0, sleep});
    chk("irq_en ret", 32'h1, {31'h0, irq_en});
    // Program counter write costs one extra instruction cycle under option 1
    q = '{13'h1803, 13'h0042, 13'h18ff, 13'h0004, 13'h1404};
    meas(1'b0, d0);
    meas(1'b1, d1);
    chk("pc write stall", CLKS_PER_CYCLE, d1 - d0);
    rchk("pc write", OFS_PC, 32'h4);
    ahb(1'b0, OFS_CORE, 32'h0, HSIZE_WORD, rd);
    chk("pc write acc", 32'h03, rd & 32'hff);
    end_of_test();
  end

  initial
  begin
    #(CLK_NS * 20000);
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
